// [hw/ssabc_pkg.sv]
package ssabc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_OFS      = 16'h0300;
	localparam logic [15:0] BAUD_OFS      = 16'h0302;
	localparam logic [15:0] PROTO_OFS     = 16'h0304;
	localparam logic [15:0] ADDR_RST      = 16'h007F;
	localparam logic [15:0] BAUD_RST      = 16'h0033;
	localparam logic [15:0] PROTO_RST     = 16'h0066;

	// ------------------------------------------------------------
	// field limits
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_MIN      = 16'h0001;
	localparam logic [15:0] ADDR_MAX      = 16'h007F;
	localparam logic [3:0]  GROUP_MAX     = 4'h7;
	localparam logic [3:0]  BAUD_CODE_MAX = 4'h5;
	localparam logic [3:0]  PROTO_CODE_MAX = 4'h8;
	localparam logic [3:0]  PROTO_RTU_MIN = 4'h6;
	localparam logic [3:0]  PROTO_8BIT_MIN = 4'h3;
	localparam logic [7:0]  BCAST_ADDR    = 8'hFF;
	localparam int          NIB_W         = 4;
	localparam int          DIV_W         = 13;
	localparam int          FMT_W         = 5;

	// ------------------------------------------------------------
	// baud divisors, clock cycles per bit, rounded to nearest
	// ------------------------------------------------------------
	localparam int CLK_HZ     = 20_000_000;
	localparam int BAUD_4800  = 4800;
	localparam int BAUD_9600  = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int BAUD_38400 = 38400;
	localparam int BAUD_57600 = 57600;
	localparam int BAUD_115K  = 115200;
	localparam logic [DIV_W-1:0] DIV_4800  =
		DIV_W'((CLK_HZ + BAUD_4800 / 2) / BAUD_4800);
	localparam logic [DIV_W-1:0] DIV_9600  =
		DIV_W'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
	localparam logic [DIV_W-1:0] DIV_19200 =
		DIV_W'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);
	localparam logic [DIV_W-1:0] DIV_38400 =
		DIV_W'((CLK_HZ + BAUD_38400 / 2) / BAUD_38400);
	localparam logic [DIV_W-1:0] DIV_57600 =
		DIV_W'((CLK_HZ + BAUD_57600 / 2) / BAUD_57600);
	localparam logic [DIV_W-1:0] DIV_115K  =
		DIV_W'((CLK_HZ + BAUD_115K / 2) / BAUD_115K);

	// frame format {rtu, eight_bits, parity_en, parity_odd, two_stop}
	localparam logic [FMT_W-1:0] FMT_RST  = 5'h19;

	// ------------------------------------------------------------
	// frame buffer
	// ------------------------------------------------------------
	localparam int          BUF_DEPTH = 2;
	localparam logic [1:0]  BUF_FULL  = 2'h2;

endpackage

// [hw/ssabc_core.sv]
// Operation
// - address holds 0x01..0x7F, resets 0x7F
// - low digit is axis, 0..F
// - second digit group 0..7, upper zero
// - frames to 0xFF always accepted, answered
// - writing 0xFF to address is refused
// - baud digit 0..5 maps 4800..115200
// - baud digits: low 232, next 485
// - protocol digit: ASCII 0-5, RTU 6-8
module ssabc_core (
	// clock and reset
	input  wire logic                      CLK,
	input  wire logic                      RST_N,
	// parameter access port
	input  wire logic                      PAR_WR,
	input  wire logic                      PAR_RD,
	input  wire logic [15:0]               PAR_ADDR,
	input  wire logic [15:0]               PAR_WDATA,
	output logic      [15:0]               PAR_RDATA,
	output logic                           PAR_ACK,
	output logic                           PAR_ERR,
	// received frame addresses
	input  wire logic                      FRM_VALID,
	input  wire logic [7:0]                FRM_ADDR,
	output logic                           FRM_READY,
	output logic                           FRM_DROP,
	// accepted frames toward the responder
	output logic                           ACC_VALID,
	output logic [7:0]                     ACC_ADDR,
	output logic                           ACC_BCAST,
	input  wire logic                      ACC_READY,
	// port configuration
	output logic [ssabc_pkg::DIV_W-1:0]    BAUD232_DIV,
	output logic [ssabc_pkg::DIV_W-1:0]    BAUD485_DIV,
	output logic [ssabc_pkg::FMT_W-1:0]    FMT232,
	output logic [ssabc_pkg::FMT_W-1:0]    FMT485
);

	// ------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------

	// station address legal: nonzero, axis any, group up to 7, rest zero
	function automatic logic addr_ok(input logic [15:0] v);
		addr_ok = (v >= ssabc_pkg::ADDR_MIN)
			&& (v <= ssabc_pkg::ADDR_MAX)
			&& (v[7:4] <= ssabc_pkg::GROUP_MAX);
	endfunction

	// two per-port digits both within limit, upper digits zero
	function automatic logic digits_ok(input logic [15:0] v,
		input logic [3:0] lim);
		digits_ok = (v[15:8] == 8'h00) && (v[3:0] <= lim)
			&& (v[7:4] <= lim);
	endfunction

	// baud code to clock cycles per bit
	function automatic logic [ssabc_pkg::DIV_W-1:0] baud_div(
		input logic [3:0] c);
		case (c)
			4'h0:    baud_div = ssabc_pkg::DIV_4800;
			4'h1:    baud_div = ssabc_pkg::DIV_9600;
			4'h2:    baud_div = ssabc_pkg::DIV_19200;
			4'h3:    baud_div = ssabc_pkg::DIV_38400;
			4'h4:    baud_div = ssabc_pkg::DIV_57600;
			default: baud_div = ssabc_pkg::DIV_115K;
		endcase
	endfunction

	// protocol code to {rtu, eight, par_en, par_odd, two_stop}
	function automatic logic [ssabc_pkg::FMT_W-1:0] proto_fmt(
		input logic [3:0] c);
		logic [1:0] par;
		par = 2'(c % 4'h3);
		proto_fmt = {c >= ssabc_pkg::PROTO_RTU_MIN,
			c >= ssabc_pkg::PROTO_8BIT_MIN,
			par != 2'h0, par == 2'h2, par == 2'h0};
	endfunction

	// ------------------------------------------------------------
	// parameter registers
	// ------------------------------------------------------------
	logic [15:0] addr_reg;
	logic [15:0] baud_reg;
	logic [15:0] proto_reg;
	logic [15:0] rdata_next;

	wire sel_addr  = PAR_ADDR == ssabc_pkg::ADDR_OFS;
	wire sel_baud  = PAR_ADDR == ssabc_pkg::BAUD_OFS;
	wire sel_proto = PAR_ADDR == ssabc_pkg::PROTO_OFS;
	wire sel_any   = sel_addr | sel_baud | sel_proto;
	// an illegal value leaves the old setting untouched
	wire wr_addr   = PAR_WR & sel_addr & addr_ok(PAR_WDATA);
	wire wr_baud   = PAR_WR & sel_baud
		& digits_ok(PAR_WDATA, ssabc_pkg::BAUD_CODE_MAX);
	wire wr_proto  = PAR_WR & sel_proto
		& digits_ok(PAR_WDATA, ssabc_pkg::PROTO_CODE_MAX);
	wire wr_good   = wr_addr | wr_baud | wr_proto;
	wire err_next  = PAR_WR ? ~wr_good : (PAR_RD & ~sel_any);

	// read mux, unmapped offsets read zero
	assign rdata_next = sel_addr  ? addr_reg  :
		sel_baud  ? baud_reg  :
		sel_proto ? proto_reg : 16'h0000;

	// settings store, power-on defaults
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			addr_reg  <= ssabc_pkg::ADDR_RST;
			baud_reg  <= ssabc_pkg::BAUD_RST;
			proto_reg <= ssabc_pkg::PROTO_RST;
		end else begin
			if (wr_addr) addr_reg <= PAR_WDATA;
			if (wr_baud) baud_reg <= PAR_WDATA;
			if (wr_proto) proto_reg <= PAR_WDATA;
		end
	end

	// answer one cycle after the request; write wins over read
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PAR_ACK   <= 1'b0;
			PAR_ERR   <= 1'b0;
			PAR_RDATA <= 16'h0000;
		end else begin
			PAR_ACK   <= PAR_WR | PAR_RD;
			PAR_ERR   <= err_next;
			PAR_RDATA <= (PAR_RD & ~PAR_WR) ? rdata_next : 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// port configuration outputs
	// ------------------------------------------------------------
	// registered so the line logic never sees a decode glitch
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BAUD232_DIV <= ssabc_pkg::DIV_38400;
			BAUD485_DIV <= ssabc_pkg::DIV_38400;
			FMT232      <= ssabc_pkg::FMT_RST;
			FMT485      <= ssabc_pkg::FMT_RST;
		end else begin
			BAUD232_DIV <= baud_div(baud_reg[3:0]);
			BAUD485_DIV <= baud_div(baud_reg[7:4]);
			FMT232      <= proto_fmt(proto_reg[3:0]);
			FMT485      <= proto_fmt(proto_reg[7:4]);
		end
	end

	// ------------------------------------------------------------
	// frame address filter and two-entry buffer
	// ------------------------------------------------------------
	logic [7:0] buf_addr [ssabc_pkg::BUF_DEPTH];
	logic       buf_bc   [ssabc_pkg::BUF_DEPTH];
	logic       wr_ptr_reg;
	logic       rd_ptr_reg;
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;

	// duplicate stations are the integrator's problem, not caught here
	wire is_bcast = FRM_ADDR == ssabc_pkg::BCAST_ADDR;
	wire is_mine  = FRM_ADDR == addr_reg[7:0];
	wire keep     = is_bcast | is_mine;
	wire take     = FRM_VALID & FRM_READY;
	wire push     = take & keep;
	wire pop      = ACC_VALID & ACC_READY;

	// a full buffer stalls every frame, dropped or not, for ordering
	assign FRM_READY = cnt_reg != ssabc_pkg::BUF_FULL;
	assign ACC_VALID = cnt_reg != 2'h0;
	assign ACC_ADDR  = buf_addr[rd_ptr_reg];
	assign ACC_BCAST = buf_bc[rd_ptr_reg];
	assign cnt_next  = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});

	// pointers, fill count and drop pulse
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg    <= 2'h0;
			FRM_DROP   <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg ^ push;
			rd_ptr_reg <= rd_ptr_reg ^ pop;
			cnt_reg    <= cnt_next;
			FRM_DROP   <= take & ~keep;
		end
	end

	// entry storage
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			buf_addr <= '{default: 8'h00};
			buf_bc   <= '{default: 1'b0};
		end else if (push) begin
			buf_addr[wr_ptr_reg] <= FRM_ADDR;
			buf_bc[wr_ptr_reg]   <= is_bcast;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_addr_bounds: assert property (
		@(posedge CLK) disable iff (!RST_N)
		addr_reg >= ssabc_pkg::ADDR_MIN && addr_reg <= ssabc_pkg::ADDR_MAX)
		else $error("station address out of range");

	a_addr_digits: assert property (
		@(posedge CLK) disable iff (!RST_N)
		addr_reg[15:8] == 8'h00 && addr_reg[7:4] <= ssabc_pkg::GROUP_MAX)
		else $error("group or upper digits illegal");

	a_axis_write: assert property (
		@(posedge CLK) disable iff (!RST_N)
		PAR_WR && sel_addr && PAR_WDATA[15:4] == 12'h001
		|=> addr_reg == $past(PAR_WDATA) && !PAR_ERR)
		else $error("legal axis digit not stored");

	a_bcast_refused: assert property (
		@(posedge CLK) disable iff (!RST_N)
		PAR_WR && sel_addr && PAR_WDATA == 16'h00FF
		|=> PAR_ACK && PAR_ERR && $stable(addr_reg))
		else $error("0xFF accepted as station address");

	a_bcast_kept: assert property (
		@(posedge CLK) disable iff (!RST_N)
		take && is_bcast |=> ACC_VALID && !FRM_DROP
		&& cnt_reg == $past(cnt_reg) + 2'h1 - 2'($past(pop)))
		else $error("broadcast frame not queued");

	a_other_drop: assert property (
		@(posedge CLK) disable iff (!RST_N)
		take && !keep |=> FRM_DROP
		&& cnt_reg == $past(cnt_reg) - 2'($past(pop)))
		else $error("foreign frame not dropped");

	a_baud_map: assert property (
		@(posedge CLK) disable iff (!RST_N)
		PAR_WR && sel_baud && PAR_WDATA == 16'h0005
		|=> ##1 BAUD232_DIV == ssabc_pkg::DIV_115K
		&& BAUD485_DIV == ssabc_pkg::DIV_4800)
		else $error("baud digit decode wrong");

	a_baud_upper: assert property (
		@(posedge CLK) disable iff (!RST_N)
		PAR_WR && sel_baud && PAR_WDATA[15:8] != 8'h00
		|=> PAR_ERR && $stable(baud_reg))
		else $error("upper baud digits accepted");

	a_proto_map: assert property (
		@(posedge CLK) disable iff (!RST_N)
		PAR_WR && sel_proto && PAR_WDATA == 16'h0082
		|=> ##1 FMT232 == 5'h06 && FMT485 == 5'h1E)
		else $error("protocol digit decode wrong");

endmodule

// [test/ssabc_resp.sv]
// ------------------------------------------------------------
// responder model on the accepted-frame side
// ------------------------------------------------------------
module ssabc_resp (
	// clock and stall control
	input  wire logic       clk,
	input  wire logic       stall,
	// accepted frame stream
	input  wire logic       acc_valid,
	input  wire logic [7:0] acc_addr,
	input  wire logic       acc_bcast,
	output logic            acc_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] got[$];
	// a slow responder just holds ready low; the buffer must keep words
	assign acc_ready = !stall;
	// log each popped entry, broadcast flag on top
	always @(posedge clk) begin
		if (acc_valid && acc_ready)
			got.push_back({acc_bcast, acc_addr});
	end
endmodule

// [test/test_serial_slave_addr_baud_config.sv]
// ------------------------------------------------------------
// parameter port and frame filter bench
// ------------------------------------------------------------
module test_serial_slave_addr_baud_config;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        fv = 1'b0, stall = 1'b0;
	logic [15:0] pa = 16'h0000, pd = 16'h0000, rdata;
	logic [7:0]  fa = 8'h00, acc_addr;
	logic        ack, err, frdy, drop, acc_valid, acc_bcast, acc_ready;
	logic [12:0] d232, d485;
	logic [4:0]  f232, f485;
	int          err_count = 0, cmp_count = 0;
	int          rate[6] = '{4800, 9600, 19200, 38400, 57600, 115200};
	// format per protocol code, {rtu, eight, par_en, par_odd, two_stop}
	logic [4:0]  fmt_tab[9] = '{5'h01, 5'h04, 5'h06, 5'h09, 5'h0C,
		5'h0E, 5'h19, 5'h1C, 5'h1E};

	ssabc_core ssabc_core_i (.CLK(clk), .RST_N(rst_n), .PAR_WR(wr),
		.PAR_RD(rd), .PAR_ADDR(pa), .PAR_WDATA(pd), .PAR_RDATA(rdata),
		.PAR_ACK(ack), .PAR_ERR(err), .FRM_VALID(fv), .FRM_ADDR(fa),
		.FRM_READY(frdy), .FRM_DROP(drop), .ACC_VALID(acc_valid),
		.ACC_ADDR(acc_addr), .ACC_BCAST(acc_bcast), .ACC_READY(acc_ready),
		.BAUD232_DIV(d232), .BAUD485_DIV(d485), .FMT232(f232),
		.FMT485(f485));
	ssabc_resp ssabc_resp_i (.clk(clk), .stall(stall),
		.acc_valid(acc_valid), .acc_addr(acc_addr),
		.acc_bcast(acc_bcast), .acc_ready(acc_ready));

	// 50 ns period
	always #25 clk = ~clk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] div_of(input int r);
		return 16'((20_000_000 + r / 2) / r);
	endfunction

	task summarize();
		if (err_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// one request pulse; answer is due exactly one cycle later
	task xfer(input logic w, input logic [15:0] a, d, e, input logic er);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		chk(ack, 1'b1);
		chk(err, er);
		if (!w)
			chk(rdata, e);
	endtask

	// offer one frame address, wait bounded for ready
	task send(input logic [7:0] a, input logic dr);
		int n;
		@(posedge clk);
		fv <= 1'b1;
		fa <= a;
		for (n = 0; n < 20; n++) begin
			#1;
			if (frdy === 1'b1)
				break;
			@(posedge clk);
		end
		if (n == 20) begin
			err_count++;
			summarize();
		end
		@(posedge clk);
		fv <= 1'b0;
		#1;
		chk(drop, dr);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int n;
		logic [4:0] f;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({3'h0, d232}, div_of(38400));
		chk({11'h0, f485}, 16'h0019);
		xfer(1'b0, 16'h0300, 16'h0, 16'h007F, 1'b0);
		xfer(1'b0, 16'h0302, 16'h0, 16'h0033, 1'b0);
		xfer(1'b0, 16'h0304, 16'h0, 16'h0066, 1'b0);
		xfer(1'b0, 16'h0306, 16'h0, 16'h0000, 1'b1);
		xfer(1'b1, 16'h0300, 16'h0001, 16'h0, 1'b0);
		xfer(1'b1, 16'h0300, 16'h001F, 16'h0, 1'b0);
		xfer(1'b0, 16'h0300, 16'h0, 16'h001F, 1'b0);
		xfer(1'b1, 16'h0300, 16'h007A, 16'h0, 1'b0);
		xfer(1'b1, 16'h0300, 16'h0000, 16'h0, 1'b1);
		xfer(1'b1, 16'h0300, 16'h0080, 16'h0, 1'b1);
		xfer(1'b1, 16'h0300, 16'h0175, 16'h0, 1'b1);
		xfer(1'b1, 16'h0300, 16'h00FF, 16'h0, 1'b1);
		xfer(1'b0, 16'h0300, 16'h0, 16'h007A, 1'b0);
		// every baud code on each port, the two ports crossed
		for (int i = 0; i < 6; i++) begin
			xfer(1'b1, 16'h0302, {8'h0, 4'(5 - i), 4'(i)}, 16'h0, 1'b0);
			@(posedge clk);
			#1;
			chk({3'h0, d232}, div_of(rate[i]));
			chk({3'h0, d485}, div_of(rate[5 - i]));
		end
		xfer(1'b1, 16'h0302, 16'h0006, 16'h0, 1'b1);
		xfer(1'b1, 16'h0302, 16'h0100, 16'h0, 1'b1);
		xfer(1'b0, 16'h0302, 16'h0, 16'h0005, 1'b0);
		// every protocol code: ASCII below six, RTU from six
		for (int i = 0; i < 9; i++) begin
			xfer(1'b1, 16'h0304, {8'h0, 4'(i), 4'(i)}, 16'h0, 1'b0);
			@(posedge clk);
			#1;
			f = fmt_tab[i];
			chk({11'h0, f232}, {11'h0, f});
			chk({11'h0, f485}, {11'h0, f});
		end
		xfer(1'b1, 16'h0304, 16'h0009, 16'h0, 1'b1);
		// ports crossed, so a swapped port shows up: 7O1 and RTU 8O1
		xfer(1'b1, 16'h0304, 16'h0082, 16'h0, 1'b0);
		@(posedge clk);
		#1;
		chk({11'h0, f232}, 16'h0006);
		chk({11'h0, f485}, 16'h001E);
		// station 0x7A is alone on the net responder stalls
		stall <= 1'b1;
		send(8'h7A, 1'b0);
		send(8'h10, 1'b1);
		send(8'hFF, 1'b0);
		chk(frdy, 1'b0);
		chk(acc_valid, 1'b1);
		stall <= 1'b0;
		for (n = 0; n < 10 && ssabc_resp_i.got.size() < 2; n++)
			@(posedge clk);
		#1;
		chk(acc_valid, 1'b0);
		chk(16'(ssabc_resp_i.got.size()), 16'h0002);
		if (ssabc_resp_i.got.size() == 2) begin
			chk({7'h0, ssabc_resp_i.got[0]}, 16'h007A);
			chk({7'h0, ssabc_resp_i.got[1]}, 16'h01FF);
		end
		summarize();
	end
endmodule
